// ### npc_flash_model.sv
// behavioural model of the nand flash facing the host controller
module npc_flash_model #(
	parameter int BUSY_NS = 300,
	parameter logic [7:0] MAKER = 8'hA5, // arbitrary value
	parameter logic [7:0] PART = 8'h3C // arbitrary value
) (
	// command pins from the host
	input wire logic i_cle,
	input wire logic i_ale,
	input wire logic i_cs_n,
	input wire logic i_we_n,
	input wire logic i_re_n,
	input wire logic i_wp_n,
	input wire logic [7:0] i_din,
	// bench-commanded program or erase failure
	input wire logic i_inj_fail,
	// answers
	output logic [7:0] o_io = 8'h5A,
	output logic o_rb = 1'b1
);
	timeunit 1ns;
	timeprecision 100ps;
	// power-up decoder sits in main-area read mode
	logic [7:0] cmd = 8'h00;
	logic [7:0] st = 8'hC0;
	logic [7:0] ptr = 8'h00;
	logic [7:0] d0, a1, a2;
	logic loaded = 1'b0;
	int na = 0;
	int nd = 0;
	int nr = 0;
	int gen = 0;
	// busy span; ready bit and pin move together
	// a newer span bumps gen so an aborted one never ends early
	task automatic go(input int ns);
		int g;
		begin
			gen++;
			g = gen;
			o_rb = 1'b0;
			st[6] = 1'b0;
			#ns;
			if (g == gen) begin
				st[0] = i_inj_fail;
				st[6] = 1'b1;
				o_rb = 1'b1;
			end
		end
	endtask
	// decode on the rising write strobe
	always @(posedge i_we_n) begin
		if (!i_cs_n && i_cle) begin
			// program start only after loading, erase start on any confirm; never when protected
			// pointer is the command written just before the data-input one
			if (i_din == 8'h80) begin
				ptr = cmd;
				loaded = 1'b1;
				nd = 0;
			end
			if (i_wp_n && ((i_din == 8'h10 && loaded) || i_din == 8'hD0))
				fork go(BUSY_NS); join_none
			// reset aborts, clears, recovers; a repeat once ready is ignored
			if (i_din == 8'hFF && !(cmd == 8'hFF && o_rb)) begin
				st = 8'hC0;
				fork go(BUSY_NS / 3); join_none
			end
			if (i_din == 8'h10)
				loaded = 1'b0;
			cmd = i_din;
			na = 0;
			nr = 0;
		end else if (!i_cs_n && i_ale) begin
			// first two address bytes kept for inspection
			if (na == 0)
				a1 = i_din;
			if (na == 1)
				a2 = i_din;
			na++;
		end else if (!i_cs_n && cmd == 8'h80) begin
			// page register takes up to 528 bytes
			if (nd == 0)
				d0 = i_din;
			if (nd < 528)
				nd++;
		end
	end
	// answer on the falling read strobe, mode held until next command
	always @(negedge i_re_n) if (!i_cs_n) begin
		if (cmd == 8'h70)
			o_io = {i_wp_n, st[6:0]};
		else if (cmd == 8'h90)
			o_io = nr == 0 ? MAKER : PART;
		nr++;
	end
	// status follows the device while the strobe stays low
	always @(st) if (!i_re_n && cmd == 8'h70) o_io = {i_wp_n, st[6:0]};
	// released bus shows the inverse so a late sample cannot pass by luck
	always @(posedge i_re_n) o_io = ~o_io;
endmodule

// ### npc_host.sv
// host-side sequencer driving a nand flash through its command pins
// Function
// - program: data-input command, three address cycles, then the data bytes.
// - end of program seen on ready/busy only; status then read with its own command.
// - erase: setup, two block address cycles, confirm; 16K-byte blocks.
// - host re-issues a read command after status at the start of each program.
// - identify command, address zero, then maker and part codes read.
// - at most 2 main and 3 spare partial programs between erases, counted for the last programmed page only.
module npc_host
	import npc_pkg::*;
#(
	parameter int MAX_BYTES = PAGE_BYTES
) (
	// clock and reset
	input wire logic i_clk,
	input wire logic i_reset_n,
	// user command port
	input wire logic i_start,
	input wire npc_op_t i_op,
	input wire logic [24:0] i_addr,
	input wire logic [9:0] i_len,
	input wire logic i_spare,
	input wire logic i_wp_release,
	output logic o_busy,
	output logic o_done,
	output logic o_fail,
	output logic [7:0] o_status,
	output logic [7:0] o_id_maker,
	output logic [7:0] o_id_part,
	// write data stream, one byte per accept
	input wire logic [7:0] i_wdata,
	output logic o_wready,
	// flash pins
	output logic o_cle,
	output logic o_ale,
	output logic o_chip_sel_n,
	output logic o_write_strobe_n,
	output logic o_read_strobe_n,
	output logic o_write_protect_n,
	input wire logic [7:0] i_io,
	output logic [7:0] o_io,
	output logic o_io_oe,
	input wire logic i_ready_busy
);
	// refuse a page size or strobe length that the counters cannot serve
	if (MAX_BYTES < 1 || MAX_BYTES > PAGE_BYTES || STROBE_CYC < 1 || STROBE_CYC > 16) begin : g_bad_cfg
		$error("bad MAX_BYTES or STROBE_CYC");
	end

	// -----------------------------------------------------------------
	// reset release
	// -----------------------------------------------------------------
	logic rst_s1_q, rst_n;
	always_ff @(posedge i_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			rst_s1_q <= 1'b0;
			rst_n <= 1'b0;
		end else begin
			rst_s1_q <= 1'b1;
			rst_n <= rst_s1_q;
		end
	end

	typedef enum logic [3:0] {
		S_IDLE, S_CMD, S_ADDR, S_DATA, S_CMD2, S_WAITBUSY, S_WAITRDY, S_READ, S_DONE
	} npc_state_t;

	typedef enum logic [1:0] {PH_SETUP, PH_LOW, PH_HIGH} npc_phase_t;

	// -----------------------------------------------------------------
	// sequencer state
	// -----------------------------------------------------------------
	npc_state_t st_q, st_d;
	npc_phase_t ph_q, ph_d;
	npc_op_t op_q, op_d;
	logic [3:0] tcnt_q, tcnt_d;
	logic [1:0] idx_q, idx_d;
	logic [9:0] left_q, left_d;
	logic [24:0] addr_q, addr_d;
	logic [7:0] byte_q, byte_d;
	logic [7:0] status_q, status_d;
	logic [7:0] maker_q, maker_d;
	logic [7:0] part_q, part_d;
	logic done_q, done_d;
	logic fail_q, fail_d;
	logic wp_n_q, wp_n_d;
	logic cle_q, cle_d, ale_q, ale_d, we_n_q, we_n_d, re_n_q, re_n_d, oe_q, oe_d;
	logic stb_done;
	logic [1:0] n_addr;
	logic [7:0] first_cmd;
	logic [15:0] page_q, page_d;
	logic [1:0] main_cnt_q, main_cnt_d, spare_cnt_q, spare_cnt_d;
	logic over_q, over_d;
	logic spare_q, spare_d;
	logic same_page;
	logic [1:0] main_used, spare_used;

	assign stb_done = (tcnt_q == 4'(STROBE_CYC - 1));
	// only the last programmed page is tracked; interleaved pages are not guarded
	assign same_page = (i_addr[24:ROW_ADDR_LO] == page_q);
	assign main_used = same_page ? main_cnt_q : 2'h0;
	assign spare_used = same_page ? spare_cnt_q : 2'h0;

	// address cycle count and opening command per operation
	always_comb begin
		n_addr = 2'd0;
		first_cmd = CMD_STATUS;
		unique case (op_q)
			NPC_OP_PROGRAM: begin
				n_addr = 2'd3;
				first_cmd = CMD_DATA_IN;
			end
			NPC_OP_ERASE: begin
				n_addr = 2'd2;
				first_cmd = CMD_ERASE_SETUP;
			end
			NPC_OP_IDENTIFY: begin
				n_addr = 2'd1;
				first_cmd = CMD_IDENTIFY;
			end
			NPC_OP_RESET: first_cmd = CMD_RESET;
			NPC_OP_STATUS: first_cmd = CMD_STATUS;
		endcase
	end

	// next-state logic: each bus cycle is setup, strobe low, strobe high
	always_comb begin
		st_d = st_q;
		ph_d = ph_q;
		op_d = op_q;
		tcnt_d = stb_done ? 4'd0 : tcnt_q + 4'd1;
		idx_d = idx_q;
		left_d = left_q;
		addr_d = addr_q;
		byte_d = byte_q;
		status_d = status_q;
		maker_d = maker_q;
		part_d = part_q;
		done_d = 1'b0;
		fail_d = fail_q;
		wp_n_d = wp_n_q;
		cle_d = cle_q;
		ale_d = ale_q;
		we_n_d = we_n_q;
		re_n_d = re_n_q;
		oe_d = oe_q;
		page_d = page_q;
		main_cnt_d = main_cnt_q;
		spare_cnt_d = spare_cnt_q;
		over_d = over_q;
		spare_d = spare_q;
		o_wready = 1'b0;
		unique case (st_q)
			S_IDLE: begin
				tcnt_d = 4'd0;
				if (i_start) begin
					op_d = i_op;
					addr_d = i_addr;
					left_d = (i_len > 10'(MAX_BYTES)) ? 10'(MAX_BYTES) : i_len;
					wp_n_d = i_wp_release;
					idx_d = 2'd0;
					ph_d = PH_SETUP;
					st_d = S_CMD;
					spare_d = i_spare;
					over_d = 1'b0;
					// partial program budget of the last programmed page
					if (i_op == NPC_OP_PROGRAM) begin
						page_d = i_addr[24:ROW_ADDR_LO];
						main_cnt_d = main_used + {1'b0, !i_spare};
						spare_cnt_d = spare_used + {1'b0, i_spare};
						if (i_spare ? (spare_used == SPARE_PARTIAL_MAX) :
							(main_used == MAIN_PARTIAL_MAX)) begin
							// refused without any strobe to the flash, reported as a failure
							over_d = 1'b1;
							wp_n_d = 1'b0;
							main_cnt_d = main_used;
							spare_cnt_d = spare_used;
							st_d = S_DONE;
						end
					end else if (i_op == NPC_OP_ERASE &&
						i_addr[24:ERASE_ADDR_LO] == page_q[15:ERASE_ADDR_LO-ROW_ADDR_LO]) begin
						// erasing the tracked page's block restores its budget
						main_cnt_d = 2'h0;
						spare_cnt_d = 2'h0;
					end
				end
			end
			S_CMD, S_CMD2, S_ADDR, S_DATA: begin
				if (ph_q == PH_SETUP) begin
					if (st_q == S_CMD) begin
						// pointer command first, so this program's data pointer is not stuck in status
						byte_d = first_cmd;
						if (op_q == NPC_OP_PROGRAM && idx_q == 2'd0) begin
							byte_d = spare_q ? CMD_SPARE_READ : CMD_MAIN_READ;
						end
					end else if (st_q == S_CMD2) begin
						byte_d = (op_q == NPC_OP_ERASE) ? CMD_ERASE_CONFIRM : CMD_PROG_CONFIRM;
					end else if (st_q == S_ADDR) begin
						unique case (op_q)
							NPC_OP_IDENTIFY: byte_d = ID_ADDR;
							// block address starts at bit 14
							NPC_OP_ERASE: byte_d = (idx_q == 2'd0) ?
								addr_q[ERASE_ADDR_LO-5 +: 8] & 8'hE0 :
								addr_q[ERASE_ADDR_LO+3 +: 8];
							default: byte_d = (idx_q == 2'd0) ? addr_q[7:0] :
								(idx_q == 2'd1) ? addr_q[ROW_ADDR_LO +: 8] :
								addr_q[ROW_ADDR_LO+8 +: 8];
						endcase
					end else if (tcnt_q == 4'd0) begin
						// one accept per byte, at the first setup cycle
						o_wready = 1'b1;
						byte_d = i_wdata;
					end
					cle_d = (st_q == S_CMD) || (st_q == S_CMD2);
					ale_d = (st_q == S_ADDR);
					oe_d = 1'b1;
					if (stb_done) begin
						ph_d = PH_LOW;
						we_n_d = 1'b0;
					end
				end else if (ph_q == PH_LOW) begin
					if (stb_done) begin
						// rising write strobe latches the byte
						we_n_d = 1'b1;
						ph_d = PH_HIGH;
					end
				end else if (stb_done) begin
					ph_d = PH_SETUP;
					cle_d = 1'b0;
					ale_d = 1'b0;
					oe_d = 1'b0;
					if (st_q == S_CMD && op_q == NPC_OP_PROGRAM && idx_q == 2'd0) begin
						idx_d = 2'd1;
					end else if (st_q == S_CMD) begin
						idx_d = 2'd0;
						if (n_addr != 2'd0) st_d = S_ADDR;
						else if (op_q == NPC_OP_RESET) st_d = S_WAITBUSY;
						else st_d = S_READ;
					end else if (st_q == S_ADDR) begin
						idx_d = idx_q + 2'd1;
						if (idx_q + 2'd1 == n_addr) begin
							idx_d = 2'd0;
							st_d = (op_q == NPC_OP_PROGRAM) ? ((left_q != 10'd0) ? S_DATA : S_CMD2) :
								(op_q == NPC_OP_ERASE) ? S_CMD2 : S_READ;
						end
					end else if (st_q == S_DATA) begin
						// byte count bounded by page size
						left_d = left_q - 10'd1;
						if (left_q == 10'd1) st_d = S_CMD2;
					end else begin
						st_d = S_WAITBUSY;
					end
				end
			end
			S_WAITBUSY: begin
				// wait for busy low, bounded so a quick reset is not missed
				if (!i_ready_busy || stb_done) st_d = S_WAITRDY;
			end
			S_WAITRDY: begin
				tcnt_d = 4'd0;
				// end of operation from the ready/busy pin
				if (i_ready_busy) begin
					// status must be asked for with its own command before the read
					st_d = (op_q == NPC_OP_RESET) ? S_DONE : S_CMD;
					op_d = (op_q == NPC_OP_RESET) ? op_q : NPC_OP_STATUS;
					idx_d = 2'd0;
					ph_d = PH_SETUP;
				end
			end
			S_READ: begin
				// status or id driven after read strobe falls
				if (ph_q == PH_SETUP) begin
					if (stb_done) begin
						re_n_d = 1'b0;
						ph_d = PH_LOW;
					end
				end else if (ph_q == PH_LOW) begin
					if (stb_done) begin
						re_n_d = 1'b1;
						ph_d = PH_HIGH;
						if (op_q == NPC_OP_IDENTIFY) begin
							if (idx_q == 2'd0) maker_d = i_io;
							else part_d = i_io;
						end else begin
							// capture status, bit 0 is the fail flag
							status_d = i_io;
						end
					end
				end else if (stb_done) begin
					ph_d = PH_SETUP;
					idx_d = idx_q + 2'd1;
					if (op_q != NPC_OP_IDENTIFY || idx_q == 2'd1) st_d = S_DONE;
				end
			end
			S_DONE: begin
				// a ready status with fail bit set, or a refused program
				fail_d = (status_q[ST_FAIL_BIT] && status_q[ST_READY_BIT]) || over_q;
				done_d = 1'b1;
				wp_n_d = 1'b0;
				st_d = S_IDLE;
			end
			default: st_d = S_IDLE;
		endcase
	end

	// sequencer registers
	always_ff @(posedge i_clk or negedge rst_n) begin
		if (!rst_n) begin
			st_q <= S_IDLE;
			ph_q <= PH_SETUP;
			op_q <= NPC_OP_STATUS;
			tcnt_q <= 4'd0;
			idx_q <= 2'd0;
			left_q <= 10'd0;
			addr_q <= 25'd0;
			byte_q <= 8'h00;
			status_q <= ST_RESET_VAL;
			maker_q <= 8'h00;
			part_q <= 8'h00;
			done_q <= 1'b0;
			fail_q <= 1'b0;
			wp_n_q <= 1'b0;
			cle_q <= 1'b0;
			ale_q <= 1'b0;
			we_n_q <= 1'b1;
			re_n_q <= 1'b1;
			oe_q <= 1'b0;
			page_q <= 16'h0000;
			main_cnt_q <= 2'h0;
			spare_cnt_q <= 2'h0;
			over_q <= 1'b0;
			spare_q <= 1'b0;
		end else begin
			st_q <= st_d;
			ph_q <= ph_d;
			op_q <= op_d;
			tcnt_q <= tcnt_d;
			idx_q <= idx_d;
			left_q <= left_d;
			addr_q <= addr_d;
			byte_q <= byte_d;
			status_q <= status_d;
			maker_q <= maker_d;
			part_q <= part_d;
			done_q <= done_d;
			fail_q <= fail_d;
			wp_n_q <= wp_n_d;
			cle_q <= cle_d;
			ale_q <= ale_d;
			we_n_q <= we_n_d;
			re_n_q <= re_n_d;
			oe_q <= oe_d;
			page_q <= page_d;
			main_cnt_q <= main_cnt_d;
			spare_cnt_q <= spare_cnt_d;
			over_q <= over_d;
			spare_q <= spare_d;
		end
	end

	// pin and user outputs, from flip-flops except wready and the chip select and busy decodes of st_q
	assign o_cle = cle_q;
	assign o_ale = ale_q;
	assign o_chip_sel_n = (st_q == S_IDLE);
	assign o_write_strobe_n = we_n_q;
	assign o_read_strobe_n = re_n_q;
	assign o_write_protect_n = wp_n_q;
	assign o_io = byte_q;
	assign o_io_oe = oe_q;
	assign o_busy = (st_q != S_IDLE);
	assign o_done = done_q;
	assign o_fail = fail_q;
	assign o_status = status_q;
	assign o_id_maker = maker_q;
	assign o_id_part = part_q;
endmodule

// ### npc_host_asserts.sv
// concurrent checks on the host controller ports
module npc_host_asserts (
	// clock, reset and user side
	input wire logic i_clk,
	input wire logic i_reset_n,
	input wire logic i_start,
	input wire logic i_ready_busy,
	input wire logic o_busy,
	input wire logic o_done,
	input wire logic o_fail,
	input wire logic [7:0] o_status,
	input wire logic o_wready,
	// flash pins
	input wire logic o_cle,
	input wire logic o_ale,
	input wire logic o_chip_sel_n,
	input wire logic o_write_strobe_n,
	input wire logic o_read_strobe_n,
	input wire logic o_write_protect_n,
	input wire logic o_io_oe
);
	timeunit 1ns;
	timeprecision 100ps;
	default clocking cb @(posedge i_clk); endclocking
	default disable iff (!i_reset_n);
	// set once the current operation has strobed a byte; a refused one never does
	logic strobed_q;
	always_ff @(posedge i_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			strobed_q <= 1'b0;
		end else if (i_start && !o_busy) begin
			strobed_q <= 1'b0;
		end else if (!o_write_strobe_n) begin
			strobed_q <= 1'b1;
		end
	end
	// strobes are five cycles low then released
	sequence s_we; !o_write_strobe_n[*5] ##1 o_write_strobe_n; endsequence
	sequence s_re; !o_read_strobe_n[*5] ##1 o_read_strobe_n; endsequence
	property p_we_len; $fell(o_write_strobe_n) |-> s_we; endproperty
	a_we_len: assert property (p_we_len) else $error("write strobe width wrong");
	property p_re_len; $fell(o_read_strobe_n) |-> s_re; endproperty
	a_re_len: assert property (p_re_len) else $error("read strobe width wrong");
	property p_wr; !o_write_strobe_n |-> o_io_oe && !o_chip_sel_n && !(o_cle && o_ale); endproperty
	a_wr: assert property (p_wr) else $error("write cycle not driven");
	property p_rd; !o_read_strobe_n |-> !o_io_oe && o_write_strobe_n && !o_cle; endproperty
	a_rd: assert property (p_rd) else $error("read cycle collides");
	property p_start; i_start && !o_busy |=> o_busy && !o_chip_sel_n; endproperty
	a_start: assert property (p_start) else $error("start not taken");
	property p_done; o_done |-> i_ready_busy ##1 !o_done; endproperty
	a_done: assert property (p_done) else $error("done while device busy");
	property p_fail; o_done |-> o_fail == ((o_status[6] && o_status[0]) || !strobed_q); endproperty
	a_fail: assert property (p_fail) else $error("fail flag disagrees");
	property p_wp; !o_busy [*2] |-> !o_write_protect_n; endproperty
	a_wp: assert property (p_wp) else $error("protect released in idle");
	property p_data; o_wready |-> !o_cle && !o_ale && o_busy; endproperty
	a_data: assert property (p_data) else $error("data taken off a data cycle");
endmodule
bind npc_host npc_host_asserts u_chk (.i_clk, .i_reset_n, .i_start, .i_ready_busy, .o_busy,
	.o_done, .o_fail, .o_status, .o_wready, .o_cle, .o_ale, .o_chip_sel_n, .o_write_strobe_n,
	.o_read_strobe_n, .o_write_protect_n, .o_io_oe);

// ### npc_host_tb_top.sv
// self-checking bench for the nand host controller
module npc_host_tb_top
	import npc_pkg::*;
;
	timeunit 1ns;
	timeprecision 100ps;
	localparam logic [7:0] MAKER = 8'h6B; // arbitrary value
	localparam logic [7:0] PART = 8'h2D; // arbitrary value
	logic i_clk, i_reset_n, i_start, i_spare, i_wp_release, inj_fail, dev_rb;
	npc_op_t i_op;
	logic [24:0] i_addr;
	logic [9:0] i_len;
	logic [7:0] i_wdata, o_status, o_id_maker, o_id_part, o_io, dev_io;
	logic o_busy, o_done, o_fail, o_wready, o_cle, o_ale, o_chip_sel_n, o_write_strobe_n;
	logic o_read_strobe_n, o_write_protect_n, o_io_oe;
	int error_cnt = 0;
	int n_checks = 0;
	npc_host DUT (.i_clk, .i_reset_n, .i_start, .i_op, .i_addr, .i_len, .i_spare, .i_wp_release,
		.o_busy, .o_done, .o_fail, .o_status, .o_id_maker, .o_id_part, .i_wdata, .o_wready,
		.o_cle, .o_ale, .o_chip_sel_n, .o_write_strobe_n, .o_read_strobe_n, .o_write_protect_n,
		.i_io(dev_io), .o_io, .o_io_oe, .i_ready_busy(dev_rb));
	npc_flash_model #(.MAKER(MAKER), .PART(PART)) flash (.i_cle(o_cle), .i_ale(o_ale),
		.i_cs_n(o_chip_sel_n), .i_we_n(o_write_strobe_n), .i_re_n(o_read_strobe_n),
		.i_wp_n(o_write_protect_n), .i_din(o_io_oe ? o_io : dev_io), .i_inj_fail(inj_fail),
		.o_io(dev_io), .o_rb(dev_rb));
	// clock
	initial begin
		i_clk = 1'b0;
		forever #2.5 i_clk = ~i_clk;
	end
	// next byte after each accepted one
	always @(posedge i_clk) if (o_wready === 1'b1) #1 i_wdata = i_wdata + 8'h01;
	task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
		n_checks++;
		if (g !== e) begin
			error_cnt++;
			$display("unexpected %s expected %h seen %h", nm, e, g);
		end
	endtask
	// one operation; waits for done under a bound
	task automatic run_op(input npc_op_t op, input logic [24:0] a, input logic wp);
		int k;
		begin
			@(posedge i_clk);
			#1;
			i_op = op;
			i_addr = a;
			i_wp_release = wp;
			i_start = 1'b1;
			@(posedge i_clk);
			#1;
			i_start = 1'b0;
			for (k = 0; k < 4000 && o_done !== 1'b1; k++) @(posedge i_clk) #1;
			chk("done seen", 8'h01, {7'h00, o_done});
			chk("busy after done", 8'h00, {7'h00, o_busy});
			chk("protect after done", 8'h00, {7'h00, o_write_protect_n});
		end
	endtask
	task automatic t_status(input logic wp, input logic [7:0] e);
		run_op(NPC_OP_STATUS, 25'h0, wp);
		chk("status", e, o_status);
		$display("status test ends");
	endtask
	task automatic t_prog(input logic f, input logic sp);
		inj_fail = f;
		i_spare = sp;
		i_wdata = 8'h30;
		run_op(NPC_OP_PROGRAM, 25'h0000A05, 1'b1);
		chk("pointer", sp ? CMD_SPARE_READ : CMD_MAIN_READ, flash.ptr);
		chk("byte count", 8'd4, 8'(flash.nd));
		chk("first byte", 8'h30, flash.d0);
		chk("column", 8'h05, flash.a1);
		chk("status", f ? 8'hC1 : 8'hC0, o_status);
		chk("fail", {7'h00, f}, {7'h00, o_fail});
		$display("program test ends");
	endtask
	task automatic t_erase;
		int g0;
		g0 = flash.gen;
		run_op(NPC_OP_ERASE, 25'h1FFFE00, 1'b1);
		chk("erase start", 8'(g0 + 1), 8'(flash.gen));
		chk("block byte 1", 8'hE0, flash.a1);
		chk("block byte 2", 8'hFF, flash.a2);
		$display("erase test ends");
	endtask
	task automatic t_reset;
		int g0;
		inj_fail = 1'b0;
		g0 = flash.gen;
		run_op(NPC_OP_RESET, 25'h0, 1'b1);
		chk("recovery span", 8'(g0 + 1), 8'(flash.gen));
		$display("reset test ends");
	endtask
	// third main program of one page is refused; erasing its block lifts the limit
	task automatic t_limit;
		int g0;
		inj_fail = 1'b0;
		i_spare = 1'b0;
		g0 = flash.gen;
		run_op(NPC_OP_PROGRAM, 25'h0000A05, 1'b1);
		chk("refused fail", 8'h01, {7'h00, o_fail});
		chk("refused start", 8'(g0), 8'(flash.gen));
		run_op(NPC_OP_ERASE, 25'h0000000, 1'b1);
		t_prog(1'b0, 1'b0);
		$display("limit test ends");
	endtask
	task automatic print_verdict;
		$display("checks %0d mismatches %0d", n_checks, error_cnt);
		if (error_cnt == 0 && n_checks > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask
	// cut a hang short, about 25 times the expected run
	initial begin
		#200000;
		error_cnt++;
		print_verdict();
	end
	// main sequence
	initial begin
		{i_reset_n, i_start, i_spare, i_wp_release, inj_fail} = 5'b00000;
		i_op = NPC_OP_STATUS;
		i_addr = 25'h0;
		i_len = 10'd4;
		i_wdata = 8'h30;
		repeat (4) @(posedge i_clk);
		#1;
		i_reset_n = 1'b1;
		repeat (3) @(posedge i_clk);
		run_op(NPC_OP_IDENTIFY, 25'h0, 1'b1);
		chk("maker", MAKER, o_id_maker);
		chk("part", PART, o_id_part);
		t_status(1'b1, 8'hC0);
		t_status(1'b0, 8'h40);
		t_prog(1'b0, 1'b0);
		t_prog(1'b1, 1'b1);
		t_reset();
		t_status(1'b1, 8'hC0);
		t_erase();
		t_status(1'b1, 8'hC0);
		t_prog(1'b0, 1'b0);
		t_limit();
		print_verdict();
	end
endmodule

// ### npc_pkg.sv
// constants shared by the nand program/erase/status host controller
package npc_pkg;
	// -----------------------------------------------------------------
	// command codes
	// -----------------------------------------------------------------
	localparam logic [7:0] CMD_MAIN_READ = 8'h00;
	localparam logic [7:0] CMD_SECOND_HALF = 8'h01;
	localparam logic [7:0] CMD_SPARE_READ = 8'h50;
	localparam logic [7:0] CMD_DATA_IN = 8'h80;
	localparam logic [7:0] CMD_PROG_CONFIRM = 8'h10;
	localparam logic [7:0] CMD_ERASE_SETUP = 8'h60;
	localparam logic [7:0] CMD_ERASE_CONFIRM = 8'hD0;
	localparam logic [7:0] CMD_STATUS = 8'h70;
	localparam logic [7:0] CMD_IDENTIFY = 8'h90;
	localparam logic [7:0] CMD_RESET = 8'hFF;
	localparam logic [7:0] ID_ADDR = 8'h00;
	// -----------------------------------------------------------------
	// status byte layout and reset value
	// -----------------------------------------------------------------
	localparam int ST_FAIL_BIT = 0;
	localparam int ST_READY_BIT = 6;
	localparam int ST_UNPROT_BIT = 7;
	localparam logic [7:0] ST_RESET_VAL = 8'hC0;
	// -----------------------------------------------------------------
	// geometry
	// -----------------------------------------------------------------
	localparam int PAGE_BYTES = 528;
	localparam int ERASE_ADDR_LO = 14;
	localparam int ROW_ADDR_LO = 9;
	// partial programs allowed on one page between erases
	localparam logic [1:0] MAIN_PARTIAL_MAX = 2'h2;
	localparam logic [1:0] SPARE_PARTIAL_MAX = 2'h3;
	// -----------------------------------------------------------------
	// strobe timing in ns at 200 MHz
	// -----------------------------------------------------------------
	localparam int CLK_NS = 5;
	localparam int STROBE_NS = 25;
	localparam int STROBE_CYC = (STROBE_NS + CLK_NS - 1) / CLK_NS;
	// operation codes at the user port
	typedef enum logic [2:0] {
		NPC_OP_PROGRAM,
		NPC_OP_ERASE,
		NPC_OP_STATUS,
		NPC_OP_IDENTIFY,
		NPC_OP_RESET
	} npc_op_t;
endpackage
